// ===== core/xdm_monitor.v
`timescale 1ns/100ps
`include "xdm_consts.vh"
module xdm_monitor (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [15:0] i_awaddr,
    input wire i_awvalid,
    output reg o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [15:0] i_araddr,
    input wire i_arvalid,
    output reg o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    input wire i_smp_valid,
    input wire [7:0] i_smp_slot,
    input wire [15:0] i_smp_value,
    input wire i_eye_valid,
    input wire [15:0] i_eye_snr0,
    input wire [15:0] i_eye_snr1,
    input wire [15:0] i_eye_snr2,
    input wire [23:0] i_eye_lvl0,
    input wire [23:0] i_eye_lvl1,
    input wire [23:0] i_eye_lvl2,
    input wire [2:0] i_eye_vzero,
    output reg o_irq
);

// ****************************************
// helpers
// ****************************************
function [31:0] xdm_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0] strb;
    integer k;
    begin
        xdm_merge = old_w;
        for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
                xdm_merge[k*8 +: 8] = new_w[k*8 +: 8];
            end
        end
    end
endfunction

function [23:0] xdm_min3;
    input [23:0] a;
    input [23:0] b;
    input [23:0] c;
    reg [23:0] m;
    begin
        m = (a < b) ? a : b;
        xdm_min3 = (c < m) ? c : m;
    end
endfunction

function xdm_mapped;
    input [15:0] a;
    begin
        xdm_mapped = (a[15:10] == `XDM_RGN_DESC) || (a[15:10] == `XDM_RGN_SMP) ||
            (a[15:10] == `XDM_RGN_THR) || (a[15:10] == `XDM_RGN_MIN) ||
            (a[15:10] == `XDM_RGN_MAX) || (a[15:10] == `XDM_RGN_AVG) ||
            (a[15:7] == `XDM_RGN_FLAG) || (a[15:7] == `XDM_RGN_MASK) ||
            (a == `XDM_ADDR_CTRL) || (a == `XDM_ADDR_STAT) ||
            (a == `XDM_ADDR_EYE) || (a == `XDM_ADDR_CAP);
    end
endfunction

// ****************************************
// storage
// ****************************************
reg [15:0] desc_q [0:255];
reg [15:0] smp_q [0:255];
reg [15:0] thr_q [0:255];
reg [31:0] flag_q [0:31];
reg [31:0] mask_q [0:31];
reg [15:0] mn_q [0:511];
reg [15:0] mx_q [0:511];
reg [31:0] sm_q [0:511];
reg [15:0] ct_q [0:511];
reg [255:0] fresh_live_q;
reg [255:0] fresh_held_q;
reg live_bank_q;
reg frozen_q;
reg [15:0] snr_q;
reg [15:0] lvl_q;
reg [15:0] aw_addr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_full_q;
reg w_full_q;
reg aw_full_d;
reg w_full_d;
reg bvalid_d;
reg rvalid_d;
reg irq_d;
integer i;
integer j;

// ****************************************
// write channel
// ****************************************
wire wr_go = aw_full_q & w_full_q & ~o_bvalid;
wire ar_go = i_arvalid & o_arready;
wire [7:0] w_idx = aw_addr_q[9:2];
wire w_desc = wr_go & (aw_addr_q[15:10] == `XDM_RGN_DESC);
wire w_thr = wr_go & (aw_addr_q[15:10] == `XDM_RGN_THR);
wire w_flag = wr_go & (aw_addr_q[15:7] == `XDM_RGN_FLAG);
wire w_mask = wr_go & (aw_addr_q[15:7] == `XDM_RGN_MASK);
wire w_ctrl = wr_go & (aw_addr_q == `XDM_ADDR_CTRL);
wire [31:0] w_bits = xdm_merge(32'h0, wdata_q, wstrb_q);
wire [31:0] w_desc_v = xdm_merge({16'h0, desc_q[w_idx]}, wdata_q, wstrb_q);
wire [31:0] w_thr_v = xdm_merge({16'h0, thr_q[w_idx]}, wdata_q, wstrb_q);
wire [31:0] w_mask_v = xdm_merge(mask_q[w_idx[4:0]], wdata_q, wstrb_q);
wire [31:0] w_ctrl_v = xdm_merge({31'h0, frozen_q}, wdata_q, wstrb_q);
// host-timed interval only, nothing internal ends it
wire frz_go = w_ctrl & w_ctrl_v[0] & ~frozen_q;
wire unfrz_go = w_ctrl & ~w_ctrl_v[0] & frozen_q;

always @* begin
    aw_full_d = (aw_full_q | (i_awvalid & o_awready)) & ~wr_go;
    w_full_d = (w_full_q | (i_wvalid & o_wready)) & ~wr_go;
    bvalid_d = (o_bvalid & ~i_bready) | wr_go;
    rvalid_d = (o_rvalid & ~i_rready) | ar_go;
end

always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        o_awready <= 1'b0;
        o_wready <= 1'b0;
        o_bvalid <= 1'b0;
        o_bresp <= `XDM_RESP_OKAY;
        aw_addr_q <= 16'h0000;
        wdata_q <= 32'h00000000;
        wstrb_q <= 4'h0;
        o_arready <= 1'b0;
        o_rvalid <= 1'b0;
    end else begin
        aw_full_q <= aw_full_d;
        w_full_q <= w_full_d;
        o_awready <= ~aw_full_d & ~bvalid_d;
        o_wready <= ~w_full_d & ~bvalid_d;
        o_bvalid <= bvalid_d;
        o_arready <= ~rvalid_d;
        o_rvalid <= rvalid_d;
        if (i_awvalid & o_awready) begin
            aw_addr_q <= i_awaddr;
        end
        if (i_wvalid & o_wready) begin
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
        end
        if (wr_go) begin
            o_bresp <= xdm_mapped(aw_addr_q) ? `XDM_RESP_OKAY : `XDM_RESP_SLVERR;
        end
    end
end

// ****************************************
// sample path and threshold check
// ****************************************
wire [15:0] s_desc = desc_q[i_smp_slot];
wire [5:0] s_set = s_desc[5:0];
wire s_used = i_smp_valid & (s_desc != 16'h0000);
// error-performance observables, by identifier in the upper byte
wire s_err = (s_desc[15:8] >= `XDM_ERR_ID_LO) && (s_desc[15:8] <= `XDM_ERR_ID_HI);
wire st_en = s_used & s_err;
reg [3:0] s_hit;
wire [31:0] s_setw = {28'h0, s_hit} << {i_smp_slot[2:0], 2'b00};

// quad order: alarm high, alarm low, warning high, warning low
always @* begin
    s_hit = 4'h0;
    if (s_used) begin
        s_hit[0] = i_smp_value > thr_q[{s_set, 2'd0}];
        s_hit[1] = i_smp_value < thr_q[{s_set, 2'd1}];
        s_hit[2] = i_smp_value > thr_q[{s_set, 2'd2}];
        s_hit[3] = i_smp_value < thr_q[{s_set, 2'd3}];
    end
end

// ****************************************
// register state
// ****************************************
always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        for (i = 0; i < 256; i = i + 1) begin
            desc_q[i] <= 16'h0000;
            smp_q[i] <= 16'h0000;
            // unimplemented limits can never be crossed
            thr_q[i] <= i[0] ? `XDM_THR_LO_RST : `XDM_THR_HI_RST;
        end
        for (i = 0; i < 32; i = i + 1) begin
            flag_q[i] <= 32'h00000000;
            mask_q[i] <= 32'h00000000;
        end
        fresh_live_q <= 256'h0;
        fresh_held_q <= 256'h0;
        live_bank_q <= 1'b0;
        frozen_q <= 1'b0;
        o_irq <= 1'b0;
    end else begin
        if (w_desc) begin
            desc_q[w_idx] <= w_desc_v[15:0];
        end
        if (w_thr) begin
            thr_q[w_idx] <= w_thr_v[15:0];
        end
        if (w_mask) begin
            mask_q[w_idx[4:0]] <= w_mask_v;
        end
        // sample stored regardless of freeze state
        if (i_smp_valid) begin
            smp_q[i_smp_slot] <= i_smp_value;
        end
        // write-one-to-clear; a new crossing wins over the clear
        for (i = 0; i < 32; i = i + 1) begin
            flag_q[i] <= (flag_q[i] & ~((w_flag && w_idx[4:0] == i) ? w_bits : 32'h0)) |
                ((i_smp_slot[7:3] == i) ? s_setw : 32'h0);
        end
        if (frz_go) begin
            frozen_q <= 1'b1;
            live_bank_q <= ~live_bank_q;
            fresh_held_q <= fresh_live_q;
            fresh_live_q <= 256'h0;
        end else if (unfrz_go) begin
            frozen_q <= 1'b0;
        end
        if (st_en) begin
            fresh_live_q[i_smp_slot] <= 1'b1;
        end
        o_irq <= irq_d;
    end
end

// pending interrupt from any unmasked set flag
always @* begin
    irq_d = 1'b0;
    for (j = 0; j < 32; j = j + 1) begin
        irq_d = irq_d | (|(flag_q[j] & ~mask_q[j]));
    end
end

// ****************************************
// interval statistics, two banks
// ****************************************
// the frozen bank is read while the other one collects, so the
// restart costs no copy of 256 entries
wire bank_n = frz_go ? ~live_bank_q : live_bank_q;
wire [8:0] st_i = {bank_n, i_smp_slot};
wire st_old = frz_go ? 1'b0 : fresh_live_q[i_smp_slot];

always @(posedge i_clk_sys) begin
    if (st_en) begin
        if (!st_old) begin
            mn_q[st_i] <= i_smp_value;
            mx_q[st_i] <= i_smp_value;
            sm_q[st_i] <= {16'h0, i_smp_value};
            ct_q[st_i] <= 16'h0001;
        end else begin
            if (i_smp_value < mn_q[st_i]) begin
                mn_q[st_i] <= i_smp_value;
            end
            if (i_smp_value > mx_q[st_i]) begin
                mx_q[st_i] <= i_smp_value;
            end
            // average freezes once the counter is full
            if (ct_q[st_i] != `XDM_CNT_MAX) begin
                sm_q[st_i] <= sm_q[st_i] + {16'h0, i_smp_value};
                ct_q[st_i] <= ct_q[st_i] + 16'h0001;
            end
        end
    end
end

// ****************************************
// PAM4 eye metrics
// ****************************************
wire [23:0] lvl_min = xdm_min3(i_eye_vzero[0] ? `XDM_LVL_OPEN : i_eye_lvl0,
    i_eye_vzero[1] ? `XDM_LVL_OPEN : i_eye_lvl1,
    i_eye_vzero[2] ? `XDM_LVL_OPEN : i_eye_lvl2);
wire [23:0] snr_min = xdm_min3({8'h0, i_eye_snr0}, {8'h0, i_eye_snr1},
    {8'h0, i_eye_snr2});

always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        snr_q <= 16'h0000;
        lvl_q <= 16'h0000;
    end else if (i_eye_valid) begin
        snr_q <= snr_min[15:0];
        if (&i_eye_vzero) begin
            lvl_q <= `XDM_LVL_INF;
        end else if (lvl_min >= `XDM_LVL_MAX) begin
            lvl_q <= `XDM_LVL_SAT;
        end else begin
            lvl_q <= lvl_min[15:0];
        end
    end
end

// ****************************************
// read channel
// ****************************************
wire [7:0] r_idx = i_araddr[9:2];
wire r_bank = frozen_q ? ~live_bank_q : live_bank_q;
wire r_fresh = frozen_q ? fresh_held_q[r_idx] : fresh_live_q[r_idx];
wire [8:0] r_si = {r_bank, r_idx};
wire [31:0] r_avg = sm_q[r_si] / {16'h0, ct_q[r_si]};
reg [31:0] rd_word;

// groups of 64 slots sit in consecutive pages of each region
always @* begin
    rd_word = 32'h00000000;
    case (i_araddr[15:10])
        `XDM_RGN_DESC: rd_word = {16'h0, desc_q[r_idx]};
        `XDM_RGN_SMP: rd_word = {16'h0, smp_q[r_idx]};
        `XDM_RGN_THR: rd_word = {16'h0, thr_q[r_idx]};
        `XDM_RGN_MIN: rd_word = r_fresh ? {16'h0, mn_q[r_si]} : 32'h0;
        `XDM_RGN_MAX: rd_word = r_fresh ? {16'h0, mx_q[r_si]} : 32'h0;
        `XDM_RGN_AVG: rd_word = r_fresh ? {16'h0, r_avg[15:0]} : 32'h0;
        default: rd_word = 32'h00000000;
    endcase
    if (i_araddr[15:7] == `XDM_RGN_FLAG) begin
        rd_word = flag_q[r_idx[4:0]];
    end
    if (i_araddr[15:7] == `XDM_RGN_MASK) begin
        rd_word = mask_q[r_idx[4:0]];
    end
    if (i_araddr == `XDM_ADDR_CTRL || i_araddr == `XDM_ADDR_STAT) begin
        rd_word = {31'h0, frozen_q};
    end
    if (i_araddr == `XDM_ADDR_EYE) begin
        rd_word = {lvl_q, snr_q};
    end
    if (i_araddr == `XDM_ADDR_CAP) begin
        rd_word = `XDM_CAP_WORD;
    end
end

always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_rdata <= 32'h00000000;
        o_rresp <= `XDM_RESP_OKAY;
    end else if (ar_go) begin
        o_rdata <= rd_word;
        o_rresp <= xdm_mapped(i_araddr) ? `XDM_RESP_OKAY : `XDM_RESP_SLVERR;
    end
end

endmodule // xdm_monitor

// ===== core/xdm_consts.vh
`ifndef XDM_CONSTS_VH
`define XDM_CONSTS_VH
// ****************************************
// address map, region codes are addr[15:10]
// ****************************************
`define XDM_RGN_DESC 6'h08
`define XDM_RGN_SMP 6'h09
`define XDM_RGN_THR 6'h0a
`define XDM_RGN_MIN 6'h0c
`define XDM_RGN_MAX 6'h0d
`define XDM_RGN_AVG 6'h0e
// flag and mask words use addr[15:7]
`define XDM_RGN_FLAG 9'h058
`define XDM_RGN_MASK 9'h05a
`define XDM_ADDR_CTRL 16'h2f00
`define XDM_ADDR_STAT 16'h2f04
`define XDM_ADDR_EYE 16'h2f08
`define XDM_ADDR_CAP 16'h018c
// ****************************************
// fields and values
// ****************************************
`define XDM_CAP_WORD 32'h00400000
`define XDM_ERR_ID_LO 8'h40
`define XDM_ERR_ID_HI 8'h5f
`define XDM_THR_HI_RST 16'hffff
`define XDM_THR_LO_RST 16'h0000
`define XDM_LVL_INF 16'hffff
`define XDM_LVL_SAT 16'hfffe
`define XDM_LVL_MAX 24'h00ffff
`define XDM_LVL_OPEN 24'hffffff
`define XDM_CNT_MAX 16'hffff
`define XDM_RESP_OKAY 2'b00
`define XDM_RESP_SLVERR 2'b10
`endif

// ===== testbench/xdm_monitor_sva.sv
`timescale 1ns/100ps
`include "xdm_consts.vh"
module xdm_monitor_sva (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [15:0] i_araddr,
    input wire i_arvalid,
    input wire o_arready,
    input wire [31:0] o_rdata,
    input wire [1:0] o_rresp,
    input wire o_rvalid,
    input wire i_awvalid,
    input wire o_awready,
    input wire i_wvalid,
    input wire o_wready,
    input wire o_bvalid,
    input wire i_bready,
    input wire i_smp_valid,
    input wire o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_rd_ans;
        i_arvalid && o_arready |=> o_rvalid && !o_arready;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_ar_block;
        o_rvalid |-> !o_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken early");
    property p_w_block;
        o_bvalid |-> !o_awready && !o_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write taken early");
    property p_wr_ans;
        i_awvalid && o_awready && i_wvalid && o_wready |=> !o_bvalid ##1 o_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer off");
    property p_cap;
        i_arvalid && o_arready && i_araddr == `XDM_ADDR_CAP
            |=> o_rdata == `XDM_CAP_WORD && o_rresp == `XDM_RESP_OKAY;
    endproperty
    a_cap: assert property (p_cap) else $error("capability word wrong");
    property p_unmap;
        i_arvalid && o_arready && i_araddr[15:12] == 4'h4 |=> o_rresp == `XDM_RESP_SLVERR;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read accepted");
    // irq follows a flag-setting sample two edges on, or a mask write
    property p_irq_rise;
        $rose(o_irq) |-> $past(i_smp_valid, 2) || $past(o_bvalid) || $past(o_bvalid, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose uncaused");
    property p_irq_fall;
        $past(i_rst_n) && $fell(o_irq) |-> $past(o_bvalid) || $past(o_bvalid, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell uncaused");
    c_irq: cover property ($rose(o_irq));
    c_wr: cover property (o_bvalid && i_bready);
    c_err: cover property (o_rvalid && o_rresp == `XDM_RESP_SLVERR);
endmodule // xdm_monitor_sva
bind xdm_monitor xdm_monitor_sva u_sva (.*);

// ===== testbench/xdm_meas_src.sv
`timescale 1ns/100ps
module xdm_meas_src (
    input wire i_clk_sys,
    output logic o_smp_valid,
    output logic [7:0] o_smp_slot,
    output logic [15:0] o_smp_value
);
    initial begin
        o_smp_valid = 1'b0;
        o_smp_slot = 8'h00;
        o_smp_value = 16'h0000;
    end
    // stale value scrambled so no idle read can pass by luck
    task automatic put(input logic [7:0] s, input logic [15:0] v);
        o_smp_valid <= 1'b1;
        o_smp_slot <= s;
        o_smp_value <= v;
        @(posedge i_clk_sys);
        o_smp_valid <= 1'b0;
        o_smp_value <= ~v;
    endtask
endmodule // xdm_meas_src

// ===== testbench/tb_diag_monitor_stats_map.sv
`timescale 1ns/100ps
`include "xdm_consts.vh"
module tb_diag_monitor_stats_map;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] i_awaddr = 16'h0000, i_araddr = 16'h0000;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_eye_valid = 1'b0;
    logic [15:0] i_eye_snr0 = 16'h0, i_eye_snr1 = 16'h0, i_eye_snr2 = 16'h0;
    logic [23:0] i_eye_lvl0 = 24'h0, i_eye_lvl1 = 24'h0, i_eye_lvl2 = 24'h0;
    logic [2:0] i_eye_vzero = 3'h0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, i_smp_valid;
    logic [1:0] o_bresp, o_rresp, resp_q;
    logic [31:0] o_rdata, rd_q, f0, f1, f2, seed = 32'h36325b96;
    logic [7:0] i_smp_slot, hi;
    logic [15:0] i_smp_value, mn, mx;
    int fails = 0, checked = 0, sm, ct;
    always #20 i_clk_sys = ~i_clk_sys;
    xdm_monitor DUT (.*);
    xdm_meas_src u_src (.i_clk_sys(i_clk_sys), .o_smp_valid(i_smp_valid),
        .o_smp_slot(i_smp_slot), .o_smp_value(i_smp_value));
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // a zero valley makes its level unbounded, so it never wins the minimum
    function automatic logic [31:0] eye_exp(input logic [15:0] s0, s1, s2,
            input logic [23:0] l0, l1, l2, input logic [2:0] z);
        logic [15:0] s;
        logic [23:0] l;
        s = (s0 < s1) ? s0 : s1;
        if (s2 < s) s = s2;
        l = 24'hffffff;
        if (!z[0] && l0 < l) l = l0;
        if (!z[1] && l1 < l) l = l1;
        if (!z[2] && l2 < l) l = l2;
        if (z == 3'h7) return {16'hffff, s};
        return {(l >= 24'h00ffff) ? 16'hfffe : l[15:0], s};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        forever begin
            @(posedge i_clk_sys);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            resp_q = o_bresp;
            if (o_bvalid) break;
        end
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        forever begin
            @(posedge i_clk_sys);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            rd_q = o_rdata;
            resp_q = o_rresp;
            if (o_rvalid) break;
        end
        i_rready <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, rd_q, exp);
    endtask
    task automatic feed(input logic [15:0] v);
        @(posedge i_clk_sys);
        u_src.put(8'h05, v);
        if (ct == 0 || v < mn) mn = v;
        if (ct == 0 || v > mx) mx = v;
        sm += v;
        ct++;
    endtask
    task automatic stats(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        rc("min", 16'h3014, a);
        rc("max", 16'h3414, b);
        rc("avg", 16'h3814, c);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        fails++;
        close_out;
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rc("cap", `XDM_ADDR_CAP, `XDM_CAP_WORD);
        rc("desc last", 16'h23fc, 32'h0);
        rc("thr hi", 16'h2800, 32'h0000ffff);
        rc("thr lo", 16'h2804, 32'h0);
        i_wstrb <= 4'h1;
        wr(16'h2800, 32'h12345678);
        i_wstrb <= 4'hf;
        rc("thr strb", 16'h2800, 32'h0000ff78);
        wr(16'h2014, 32'h00004102);
        rc("desc", 16'h2014, 32'h00004102);
        wr(16'h2820, 32'h000003e8);
        wr(16'h2828, 32'h000001f4);
        rc("thr", 16'h2828, 32'h000001f4);
        ct = 0;
        sm = 0;
        feed(16'h0258);
        rc("smp", 16'h2414, 32'h00000258);
        rc("flag warn", 16'h2c00, 32'h00400000);
        chk("irq", o_irq, 32'h1);
        feed(16'h04b0);
        rc("flag alarm", 16'h2c00, 32'h00500000);
        wr(16'h2d00, 32'h00500000);
        rc("mask", 16'h2d00, 32'h00500000);
        chk("irq masked", o_irq, 32'h0);
        wr(16'h2c00, 32'h00500000);
        rc("flag clr", 16'h2c00, 32'h0);
        wr(16'h2d00, 32'h0);
        wr(16'h2f00, 32'h1);
        wr(16'h2f00, 32'h0);
        rc("min empty", 16'h3014, 32'h0);
        ct = 0;
        sm = 0;
        repeat (6) begin
            seed = lfsr(seed);
            feed({8'h00, seed[7:0]});
        end
        stats({16'h0, mn}, {16'h0, mx}, sm / ct);
        f0 = {16'h0, mn};
        f1 = {16'h0, mx};
        f2 = sm / ct;
        wr(16'h2f00, 32'h1);
        rc("frozen", 16'h2f04, 32'h1);
        ct = 0;
        sm = 0;
        repeat (4) begin
            seed = lfsr(seed);
            feed({8'h00, seed[7:0]});
        end
        stats(f0, f1, f2);
        rc("smp frozen", 16'h2414, {24'h0, seed[7:0]});
        wr(16'h2f00, 32'h0);
        stats({16'h0, mn}, {16'h0, mx}, sm / ct);
        wr(16'h2018, 32'h00001002);
        @(posedge i_clk_sys);
        u_src.put(8'h06, 16'h0007);
        rc("smp other", 16'h2418, 32'h7);
        rc("no stats", 16'h3018, 32'h0);
        wr(16'h4000, 32'h1);
        chk("bresp", resp_q, `XDM_RESP_SLVERR);
        rd(16'h4000);
        chk("rresp", resp_q, `XDM_RESP_SLVERR);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            hi = (k == 1) ? 8'h03 : 8'h00;
            @(posedge i_clk_sys);
            i_eye_snr0 <= seed[15:0];
            i_eye_snr1 <= seed[31:16];
            i_eye_snr2 <= seed[23:8];
            i_eye_lvl0 <= {hi, seed[31:16]};
            i_eye_lvl1 <= {hi, seed[15:0]};
            i_eye_lvl2 <= {hi, seed[23:8]};
            i_eye_vzero <= (k == 2) ? 3'h7 : {1'b0, seed[1:0]};
            i_eye_valid <= 1'b1;
            @(posedge i_clk_sys);
            i_eye_valid <= 1'b0;
            rc("eye", `XDM_ADDR_EYE, eye_exp(i_eye_snr0, i_eye_snr1, i_eye_snr2,
                i_eye_lvl0, i_eye_lvl1, i_eye_lvl2, i_eye_vzero));
        end
        close_out;
    end
endmodule // tb_diag_monitor_stats_map
